/* src/freq_meter_regs.vh */
// constants used by the frequency meter channel, including the layout of its synchroniser bundle
`ifndef FREQ_METER_REGS_VH
`define FREQ_METER_REGS_VH

// system clock period and the resolution of the counting period
`define CLK_PERIOD_NS 100
`define PERIOD_STEP_NS 25
// period steps consumed per clock cycle, derived from the two times above
`define STEPS_PER_CLK (`CLK_PERIOD_NS / `PERIOD_STEP_NS)

// widths of the period parameter and of the pulse counters
`define PERIOD_W 30
`define COUNT_W 32

// number of external inputs that pass through the synchroniser
`define EXT_IN_W 3
// bit positions of the external inputs inside the synchroniser bundle
`define EXT_PULSE_BIT 0
`define EXT_START_BIT 1
`define EXT_GATE_BIT 2

// measurement mode encodings
`define MODE_SINGLE 1'b0
`define MODE_SERIES 1'b1

// trigger source encodings
`define SRC_SOFT 1'b0
`define SRC_PINS 1'b1

// reset values
`define COUNT_RST 32'h0000_0000
`define PERIOD_RST 30'h0000_0000

`endif

/* src/gated_pulse_frequency_meter.v */
// one gated pulse frequency meter channel
//
// What this block does
// - only reacts while block_enable is 1; disabled holds ready and pending low
// - source select 0 takes soft start/gate, 1 takes the external pins
// - gate_polarity_flip 1 inverts the selected gate signal
// - start_polarity_flip 1 inverts the selected start so falling edges launch
// - input_polarity_flip 1 inverts the pulse input so falling edges count
// - start rising edge clears ready, sets pending, loads period length
// - counting period is timed in 25 ns steps of the period parameter
// - pulse edges count only while pending or continuous counting is 1
// - in single mode, period expiry clears pending, ending the measurement cycle
// - while effective gate is 1 no pulse edge is counted
// - gate scope 1 also freezes the period timer while gated; 0 keeps it running
// - single measurement end copies running count to result and sets ready
// - series mode restarts immediately, result holds last completed count
// - counting period length parameter is 30 bits wide
// - measurement result is a 32-bit read-only value
`timescale 1ns/100ps
`default_nettype none
`include "freq_meter_regs.vh"

module gated_pulse_frequency_meter #(
    parameter PERIOD_W = `PERIOD_W,
    parameter COUNT_W = `COUNT_W
) (
    input wire clk,
    input wire rst,
    // channel control bits
    input wire block_enable,
    input wire trigger_source_select,
    input wire soft_start,
    input wire soft_gate,
    input wire gate_polarity_flip,
    input wire start_polarity_flip,
    input wire input_polarity_flip,
    input wire continuous_count_flag,
    input wire gate_scope_select,
    input wire series_mode,
    input wire [PERIOD_W-1:0] period_steps,
    // external pins
    input wire pulse_input,
    input wire ext_start_pin,
    input wire ext_gate_pin,
    // status and results
    output wire ready,
    output wire pending,
    output wire [COUNT_W-1:0] running_count,
    output wire [COUNT_W-1:0] result
);

    // period steps eaten per clock; the step is finer than the clock period,
    // so a period is rounded up to whole clocks and never lasts under one
    localparam integer STEPS_INT = `STEPS_PER_CLK;
    localparam [PERIOD_W-1:0] STEP_DEC = STEPS_INT[PERIOD_W-1:0];
    localparam [COUNT_W-1:0] COUNT_ONE = {{(COUNT_W-1){1'b0}}, 1'b1};

    wire [`EXT_IN_W-1:0] ext_raw;
    wire [`EXT_IN_W-1:0] ext_sync;

    reg start_prev_r;
    reg pulse_prev_r;
    reg arm_r;
    reg ready_r;
    reg ready_nxt;
    reg pending_r;
    reg pending_nxt;
    reg [PERIOD_W-1:0] remain_r;
    reg [PERIOD_W-1:0] remain_nxt;
    reg [COUNT_W-1:0] count_r;
    reg [COUNT_W-1:0] count_nxt;
    reg [COUNT_W-1:0] result_r;
    reg [COUNT_W-1:0] result_nxt;

    wire start_sel;
    wire gate_sel;
    wire start_eff;
    wire gate_eff;
    wire pulse_eff;
    wire start_edge;
    wire pulse_edge;
    wire count_en;
    wire count_inc;
    wire timer_run;
    wire period_done;
    wire [COUNT_W-1:0] count_plus;

    // bundle the asynchronous pins for one shared synchroniser
    assign ext_raw[`EXT_PULSE_BIT] = pulse_input;
    assign ext_raw[`EXT_START_BIT] = ext_start_pin;
    assign ext_raw[`EXT_GATE_BIT] = ext_gate_pin;

    // two flops per pin; costs two cycles of latency but each edge counts once
    input_sync #(
        .WIDTH(`EXT_IN_W)
    ) pin_sync (
        .clk(clk),
        .rst(rst),
        .async_in(ext_raw),
        .sync_out(ext_sync)
    );

    // pick the trigger source; soft bits are already synchronous
    assign start_sel = (trigger_source_select == `SRC_PINS) ?
                       ext_sync[`EXT_START_BIT] : soft_start;
    assign gate_sel = (trigger_source_select == `SRC_PINS) ?
                      ext_sync[`EXT_GATE_BIT] : soft_gate;

    // optional polarity flips
    assign start_eff = start_sel ^ start_polarity_flip;
    assign gate_eff = gate_sel ^ gate_polarity_flip;
    assign pulse_eff = ext_sync[`EXT_PULSE_BIT] ^ input_polarity_flip;

    // rising edges of the effective signals; toggling a flip bit while the
    // source is steady looks like an edge, so change flips while idle
    assign start_edge = start_eff & ~start_prev_r & arm_r;
    assign pulse_edge = pulse_eff & ~pulse_prev_r & arm_r;

    // counting window and gating
    assign count_en = pending_r | continuous_count_flag;
    assign count_inc = pulse_edge & count_en & ~gate_eff;
    assign count_plus = count_r + COUNT_ONE;

    // gate scope decides whether gating also stops the period timer
    assign timer_run = pending_r & ~(gate_scope_select & gate_eff);
    // the period ends on the cycle that consumes its last 25 ns steps
    assign period_done = timer_run & (remain_r <= STEP_DEC);

    // previous levels for edge detection track even while disabled, so that
    // enabling with start already high does not launch a measurement
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            start_prev_r <= 1'b0;
            pulse_prev_r <= 1'b0;
        end else begin
            start_prev_r <= start_eff;
            pulse_prev_r <= pulse_eff;
        end
    end

    // edge detection waits one cycle after reset: the previous-level flops
    // reset low, which would fake an edge on any effective input idling high
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            arm_r <= 1'b0;
        end else begin
            arm_r <= 1'b1;
        end
    end

    // next state of the measurement; start wins over a coincident expiry
    always @* begin
        ready_nxt = ready_r;
        pending_nxt = pending_r;
        remain_nxt = remain_r;
        count_nxt = count_r;
        result_nxt = result_r;
        if (!block_enable) begin
            // disabled: flags low, counters and result frozen
            ready_nxt = 1'b0;
            pending_nxt = 1'b0;
        end else if (start_edge) begin
            ready_nxt = 1'b0;
            pending_nxt = 1'b1;
            remain_nxt = period_steps;
            count_nxt = `COUNT_RST;
            // single mode shows zero in the result until the period ends
            if (series_mode == `MODE_SINGLE) begin
                result_nxt = `COUNT_RST;
            end
        end else begin
            // pulses that are gated or fall outside the window are dropped
            if (count_inc) begin
                count_nxt = count_plus;
            end
            if (period_done) begin
                // an edge landing in the final cycle still belongs to this result
                result_nxt = count_inc ? count_plus : count_r;
                ready_nxt = 1'b1;
                if (series_mode == `MODE_SERIES) begin
                    // back-to-back periods with no dead cycle between them
                    pending_nxt = 1'b1;
                    remain_nxt = period_steps;
                    count_nxt = `COUNT_RST;
                end else begin
                    pending_nxt = 1'b0;
                    remain_nxt = {PERIOD_W{1'b0}};
                end
            end else if (timer_run) begin
                // a frozen timer keeps its remaining steps untouched
                remain_nxt = remain_r - STEP_DEC;
            end
        end
    end

    // measurement state registers
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ready_r <= 1'b0;
            pending_r <= 1'b0;
            remain_r <= `PERIOD_RST;
            count_r <= `COUNT_RST;
            result_r <= `COUNT_RST;
        end else begin
            ready_r <= ready_nxt;
            pending_r <= pending_nxt;
            remain_r <= remain_nxt;
            count_r <= count_nxt;
            result_r <= result_nxt;
        end
    end

    // all status and data outputs come straight from flip-flops
    assign ready = ready_r;
    assign pending = pending_r;
    assign running_count = count_r;
    assign result = result_r;

endmodule // gated_pulse_frequency_meter

`default_nettype wire

/* src/input_sync.v */
// two flip-flop synchroniser for a bundle of asynchronous level inputs
`timescale 1ns/100ps
`default_nettype none

module input_sync #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] stable_r;

    // first stage feeds only the second stage, never any logic
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= {WIDTH{1'b0}};
            stable_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= async_in;
            stable_r <= meta_r;
        end
    end

    assign sync_out = stable_r;

endmodule // input_sync

`default_nettype wire

/* verif/fm_checker.sv */
// port assertions for the gated pulse frequency meter channel
`timescale 1ns/100ps
`default_nettype none
module fm_checker #(
    parameter PERIOD_W = 30,
    parameter COUNT_W = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic block_enable,
    input wire logic trigger_source_select,
    input wire logic soft_start,
    input wire logic soft_gate,
    input wire logic gate_polarity_flip,
    input wire logic start_polarity_flip,
    input wire logic continuous_count_flag,
    input wire logic gate_scope_select,
    input wire logic series_mode,
    input wire logic [PERIOD_W-1:0] period_steps,
    input wire logic ready,
    input wire logic pending,
    input wire logic [COUNT_W-1:0] running_count,
    input wire logic [COUNT_W-1:0] result
);
    logic st_q;
    logic armed_q;
    // soft path only: pin levels reach the core late, so they are judged by the bench
    wire logic st = soft_start ^ start_polarity_flip;
    wire logic gt = soft_gate ^ gate_polarity_flip;
    wire logic soft_ok = block_enable && !trigger_source_select;
    wire logic launch = soft_ok && st && !st_q && armed_q;
    // edges are judged only from the second edge after reset, as in the core
    always @(posedge clk or posedge rst) begin
        st_q <= rst ? 1'b0 : st;
        armed_q <= !rst;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_launch;
        launch && !series_mode && period_steps == 8;
    endsequence
    sequence s_quiet;
        soft_ok && !launch && !series_mode && !gate_scope_select;
    endsequence
    a_off_clears: assert property (!block_enable |=> !ready && !pending)
        else $error("flags up while disabled");
    a_launch_flags: assert property (launch
        |=> pending && !ready && running_count == 0)
        else $error("start not taken");
    a_gate_holds: assert property (soft_ok && gt && !series_mode && !launch
        |=> $stable(running_count))
        else $error("counted while gated");
    a_idle_holds: assert property (soft_ok && !pending && !continuous_count_flag
        && !launch |=> $stable(running_count))
        else $error("counted while idle");
    a_count_step: assert property (soft_ok && !series_mode && !launch
        |=> running_count - $past(running_count) <= 1)
        else $error("count jumped");
    a_single_ends: assert property (s_launch ##1 s_quiet [*2]
        |=> !pending && ready && result == running_count)
        else $error("period end wrong");
    a_ready_keeps: assert property (soft_ok && ready && !pending && !launch
        |=> ready && $stable(result))
        else $error("result moved");
    a_frozen_timer: assert property (soft_ok && gate_scope_select && gt && pending
        && !launch |=> pending)
        else $error("timer ran while gated");
    a_series_keeps: assert property (soft_ok && series_mode && pending && !launch
        |=> pending)
        else $error("series run stopped");
endmodule // fm_checker
bind gated_pulse_frequency_meter fm_checker #(.PERIOD_W(PERIOD_W), .COUNT_W(COUNT_W)) u_chk (
    .clk(clk), .rst(rst), .block_enable(block_enable),
    .trigger_source_select(trigger_source_select),
    .soft_start(soft_start), .soft_gate(soft_gate), .gate_polarity_flip(gate_polarity_flip),
    .start_polarity_flip(start_polarity_flip), .continuous_count_flag(continuous_count_flag),
    .gate_scope_select(gate_scope_select), .series_mode(series_mode),
    .period_steps(period_steps),
    .ready(ready), .pending(pending), .running_count(running_count), .result(result));
`default_nettype wire

/* verif/pin_source.sv */
// far-side pulse, start and gate pin sources
`timescale 1ns/100ps
`default_nettype none
module pin_source (
    input wire logic clk,
    input wire logic run,
    input wire logic [3:0] half,
    input wire logic start_lvl,
    input wire logic gate_lvl,
    output logic pulse_input,
    output logic ext_start_pin,
    output logic ext_gate_pin,
    output int rises,
    output int falls
);
    int k = 0;
    initial begin
        pulse_input = 1'b0;
        rises = 0;
        falls = 0;
    end
    // pins move 37 ns after the edge, unrelated to sampling; each level lasts half clocks
    always @(posedge clk) begin
        #37;
        ext_start_pin = start_lvl;
        ext_gate_pin = gate_lvl;
        k = run ? k + 1 : 0;
        if (run && k >= half) begin
            k = 0;
            rises = rises + !pulse_input;
            falls = falls + pulse_input;
            pulse_input = !pulse_input;
        end
    end
endmodule // pin_source
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the gated pulse frequency meter channel
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, rst = 1'b1, en = 1'b0, sel = 1'b0, sst = 1'b0, sgt = 1'b0, gfl = 1'b0;
    logic sfl = 1'b0, ifl = 1'b0, cont = 1'b0, scope = 1'b0, ser = 1'b0, run = 1'b0;
    logic slvl = 1'b0, glvl = 1'b0, ready, pending, pin_p, pin_s, pin_g;
    logic [3:0] half = 4'h2;
    logic [7:0] lf = 8'h4a;
    logic [29:0] steps = 30'h0000_0008;
    logic [31:0] cnt, res;
    int rises, falls, base, mismatches = 0, num_checks = 0;
    initial forever #50 clk = ~clk;
    pin_source i_pin_source (.clk(clk), .run(run), .half(half), .start_lvl(slvl),
        .gate_lvl(glvl), .pulse_input(pin_p), .ext_start_pin(pin_s), .ext_gate_pin(pin_g),
        .rises(rises), .falls(falls));
    gated_pulse_frequency_meter i_gated_pulse_frequency_meter (.clk(clk), .rst(rst),
        .block_enable(en), .trigger_source_select(sel), .soft_start(sst), .soft_gate(sgt),
        .gate_polarity_flip(gfl), .start_polarity_flip(sfl), .input_polarity_flip(ifl),
        .continuous_count_flag(cont), .gate_scope_select(scope), .series_mode(ser),
        .period_steps(steps), .pulse_input(pin_p), .ext_start_pin(pin_s),
        .ext_gate_pin(pin_g), .ready(ready), .pending(pending), .running_count(cnt), .result(res));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // edges of the counted polarity since the snapshot
    function automatic logic [31:0] counted(input logic flip, input int b);
        return 32'((flip ? falls : rises) - b);
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        $display("mismatches %0d, checks %0d", mismatches, num_checks);
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // raise the effective start on the selected source only, then return to idle
    task launch;
        if (sel) begin
            slvl = !sfl;
        end else begin
            sst = !sfl;
        end
        cyc(5);
        sst = sfl;
        slvl = sfl;
    endtask
    initial begin
        cyc(5);
        rst = 1'b0;
        chk({30'h0, ready, pending}, 32'h0);
        chk(cnt | res, 32'h0);
        en = 1'b1;
        // sweep sources and polarities with random gate flip, period and pulse rate;
        // the unselected gate is held active so a core reading it counts nothing
        for (int i = 0; i < 8; i++) begin
            lf = lfsr(lf);
            {sel, sfl, ifl} = 3'(i);
            {gfl, sgt, glvl} = {lf[0], lf[0] ^ sel, lf[0] ^ !sel};
            sst = sfl;
            slvl = sfl;
            half = 4'(lf[2:1]) + 4'h1;
            steps = 30'(lf) + 30'h0000_0190;
            cyc(6);
            base = ifl ? falls : rises;
            launch;
            chk({ready, pending}, 2'b01);
            run = 1'b1;
            cyc(40);
            run = 1'b0;
            cyc(5);
            chk(cnt, counted(ifl, base));
            for (int n = 0; n < 200 && pending !== 1'b0; n++) cyc(1);
            chk({ready, pending}, 2'b10);
            chk(res, counted(ifl, base));
        end
        {sel, sfl, ifl} = 3'h0;
        sst = 1'b0;
        steps = 30'h0000_0008;
        for (int s = 0; s < 2; s++) begin
            scope = s[0];
            sgt = !gfl;
            launch;
            run = 1'b1;
            cyc(20);
            run = 1'b0;
            // let the synchroniser drain while still gated
            cyc(4);
            chk(cnt, 0);
            chk(pending, scope);
            sgt = gfl;
            cyc(4);
            chk({ready, pending}, 2'b10);
        end
        cont = 1'b1;
        base = rises;
        run = 1'b1;
        cyc(20);
        run = 1'b0;
        cyc(5);
        chk(cnt, counted(1'b0, base));
        cont = 1'b0;
        ser = 1'b1;
        launch;
        cyc(10);
        chk({ready, pending}, 2'b11);
        en = 1'b0;
        cyc(2);
        chk({ready, pending}, 2'b00);
        sst = 1'b1;
        cyc(4);
        chk(pending, 1'b0);
        report_and_stop;
    end
    // the run needs under 2000 cycles; 6000 means a hang
    initial begin
        #600000;
        mismatches++;
        report_and_stop;
    end
endmodule // tb_top
`default_nettype wire
